/* sync_cycle_core.sv */
// Subordinate controller cycle synchronisation with sync parameter registers
// Operation
// R01: Local cycle faster than communication cycle supported
// R02: Output-valid and input-latch shifting both used
// R03: Each first sync pulse starts local cycle
// R04: Second sync pulse triggers output and input instants
// R05: Instants moved only by configured shift times
// R06: Output sync type reads 0x03
// R07: Input sync type reads 0x01
// R08: Output cycle time reports second pulse period
// R09: Application may copy period into cycle time
// R10: Supported types bits 3:2 read 10
// R11: Output supported bits 5:4 show shift mode
// R12: Input supported bits 5:4 show shift mode
// R13: Input cycle time equals output cycle time
// R14: Input counters and period mirror output entries
// R15: Sync error entry provided with optional counters
// R16: Writable get cycle time entry provided
// R17: Overrun counts too-small and asserts sync error
`timescale 1ns/1ps
`default_nettype none
module sync_cycle_core
	import sync_cycle_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic [31:0]      reg_rdata,
	// Sync pulses and measured periods
	input  wire logic        first_pulse,
	input  wire logic        second_pulse,
	input  wire logic [31:0] second_period,
	input  wire logic [31:0] first_period,
	// Local application events
	input  wire logic        cycle_done,
	input  wire logic        missed_event,
	input  wire logic        toggle_failed,
	// Timing outputs
	output logic             cycle_start,
	output logic             output_valid,
	output logic             input_latch,
	output logic             irq
);
	logic [31:0]          out_cycle_time_reg;
	logic [31:0]          out_shift_time_reg;
	logic [31:0]          in_shift_time_reg;
	logic [15:0]          get_cycle_reg;
	logic [31:0]          first_period_reg;
	logic [15:0]          too_small_reg;
	logic [15:0]          missed_reg;
	logic [15:0]          shift_short_reg;
	logic [15:0]          toggle_fail_reg;
	logic                 sync_error_reg;
	logic [3:0]           control_reg;
	logic [IRQ_WIDTH-1:0] irq_status_reg;
	logic [IRQ_WIDTH-1:0] irq_enable_reg;
	logic                 cycle_busy_reg;
	logic                 overrun;
	logic                 out_fire;
	logic                 in_fire;
	logic                 out_short;
	logic                 in_short;
	logic                 any_short;
	logic [IRQ_WIDTH-1:0] irq_events;
	logic [15:0]          out_supported;
	logic [15:0]          in_supported;
	logic [31:0]          rdata_next;

	// Overrun: a new first pulse while the previous local cycle is still busy
	assign overrun   = first_pulse && cycle_busy_reg && !cycle_done;
	assign any_short = out_short || in_short;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			cycle_start    <= 1'b0;
			cycle_busy_reg <= 1'b0;
		end
		else
		begin
			cycle_start <= first_pulse; // R01 R03
			if (first_pulse)
				cycle_busy_reg <= 1'b1;
			else if (cycle_done)
				cycle_busy_reg <= 1'b0;
		end
	end

	// Both instants come from the second pulse, delayed only by their shift time
	shift_timer u_out_shift (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.enable    (control_reg[CTL_OUT_SHIFT_EN]),
		.shift_ns  (out_shift_time_reg),
		.trigger   (second_pulse), // R02 R04 R05
		.fire      (out_fire),
		.too_short (out_short)
	);

	shift_timer u_in_shift (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.enable    (control_reg[CTL_IN_SHIFT_EN]),
		.shift_ns  (in_shift_time_reg),
		.trigger   (second_pulse), // R02 R04 R05
		.fire      (in_fire),
		.too_short (in_short)
	);

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			output_valid <= 1'b0;
			input_latch  <= 1'b0;
		end
		else
		begin
			output_valid <= out_fire; // R04
			input_latch  <= in_fire; // R04
		end
	end

	// Configuration written by software; the cycle time follows the measured period
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			out_cycle_time_reg <= 32'h0;
			out_shift_time_reg <= 32'h0;
			in_shift_time_reg  <= 32'h0;
			get_cycle_reg      <= 16'h0;
			control_reg        <= 4'h0;
			irq_enable_reg     <= '0;
			first_period_reg   <= 32'h0;
		end
		else
		begin
			if (second_pulse)
				out_cycle_time_reg <= second_period; // R08
			else if (reg_write && reg_addr == IDX_OUT_CYCLE_TIME)
				out_cycle_time_reg <= reg_wdata; // R09
			if (first_pulse)
				first_period_reg <= first_period;
			if (reg_write)
			begin
				case (reg_addr)
					IDX_OUT_SHIFT_TIME: out_shift_time_reg <= reg_wdata;
					IDX_IN_SHIFT_TIME:  in_shift_time_reg  <= reg_wdata;
					IDX_OUT_GET_CYCLE:  get_cycle_reg      <= reg_wdata[15:0]; // R16
					IDX_CONTROL:        control_reg        <= reg_wdata[3:0];
					IDX_IRQ_ENABLE:     irq_enable_reg     <= reg_wdata[IRQ_WIDTH-1:0];
					default:            control_reg        <= control_reg;
				endcase
			end
		end
	end

	// Saturating error counters; the count-clear bit zeroes them
	always_ff @(posedge clk_sys)
	begin
		if (reset || control_reg[CTL_COUNT_CLR])
		begin
			too_small_reg   <= 16'h0;
			missed_reg      <= 16'h0;
			shift_short_reg <= 16'h0;
			toggle_fail_reg <= 16'h0;
			sync_error_reg  <= 1'b0;
		end
		else
		begin
			if (overrun && too_small_reg != 16'hffff)
				too_small_reg <= too_small_reg + 16'h1; // R17
			if (missed_event && missed_reg != 16'hffff)
				missed_reg <= missed_reg + 16'h1;
			if (any_short && shift_short_reg != 16'hffff)
				shift_short_reg <= shift_short_reg + 16'h1;
			if (toggle_failed && toggle_fail_reg != 16'hffff)
				toggle_fail_reg <= toggle_fail_reg + 16'h1;
			// Error follows the last first pulse: set on an overrun, missed event or short shift, cleared on a clean first pulse
			if (overrun || missed_event || any_short)
				sync_error_reg <= 1'b1; // R15 R17
			else if (first_pulse)
				sync_error_reg <= 1'b0;
		end
	end

	// Sticky interrupt status; a set in the clearing cycle wins
	assign irq_events = {toggle_failed, any_short, missed_event, overrun};

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			irq_status_reg <= '0;
			irq            <= 1'b0;
		end
		else
		begin
			if (reg_write && reg_addr == IDX_IRQ_CLEAR)
				irq_status_reg <= (irq_status_reg & ~reg_wdata[IRQ_WIDTH-1:0]) | irq_events;
			else
				irq_status_reg <= irq_status_reg | irq_events;
			irq <= |(irq_status_reg & irq_enable_reg);
		end
	end

	assign out_supported = 16'(({12'h0, control_reg[CTL_OUT_SHIFT_EN] ? SHIFT_LOCAL_TIMER : SHIFT_NONE}
		<< SUPP_SHIFT_LSB) | (16'(SUPP_SUBORDINATE) << SUPP_DC_LSB)); // R10 R11
	assign in_supported  = 16'(({12'h0, control_reg[CTL_IN_SHIFT_EN] ? SHIFT_LOCAL_TIMER : SHIFT_NONE}
		<< SUPP_SHIFT_LSB) | (16'(SUPP_SUBORDINATE) << SUPP_DC_LSB)); // R10 R12

	always_comb
	begin
		case (reg_addr)
			IDX_OUT_SYNC_TYPE:   rdata_next = {16'h0, OUT_SYNC_TYPE_RST}; // R06
			IDX_OUT_CYCLE_TIME:  rdata_next = out_cycle_time_reg; // R08
			IDX_OUT_SHIFT_TIME:  rdata_next = out_shift_time_reg;
			IDX_OUT_SUPPORTED:   rdata_next = {16'h0, out_supported};
			IDX_OUT_MIN_CYCLE:   rdata_next = MIN_CYCLE_RST;
			IDX_OUT_CALC_COPY:   rdata_next = CALC_COPY_RST;
			IDX_OUT_GET_CYCLE:   rdata_next = {16'h0, get_cycle_reg}; // R16
			IDX_OUT_DELAY:       rdata_next = DELAY_RST;
			IDX_OUT_FIRST_PER,
			IDX_IN_FIRST_PER:    rdata_next = first_period_reg; // R14
			IDX_OUT_TOO_SMALL,
			IDX_IN_TOO_SMALL:    rdata_next = {16'h0, too_small_reg}; // R14
			IDX_OUT_MISSED,
			IDX_IN_MISSED:       rdata_next = {16'h0, missed_reg}; // R14
			IDX_OUT_SHIFT_SHORT,
			IDX_IN_SHIFT_SHORT:  rdata_next = {16'h0, shift_short_reg}; // R14
			IDX_OUT_TOGGLE_FAIL,
			IDX_IN_TOGGLE_FAIL:  rdata_next = {16'h0, toggle_fail_reg}; // R14
			IDX_OUT_SYNC_ERROR,
			IDX_IN_SYNC_ERROR:   rdata_next = {31'h0, sync_error_reg}; // R15
			IDX_IN_SYNC_TYPE:    rdata_next = {16'h0, IN_SYNC_TYPE_RST}; // R07
			IDX_IN_CYCLE_TIME:   rdata_next = out_cycle_time_reg; // R13
			IDX_IN_SHIFT_TIME:   rdata_next = in_shift_time_reg;
			IDX_IN_SUPPORTED:    rdata_next = {16'h0, in_supported};
			IDX_CONTROL:         rdata_next = {28'h0, control_reg};
			IDX_IRQ_STATUS:      rdata_next = {28'h0, irq_status_reg};
			IDX_IRQ_ENABLE:      rdata_next = {28'h0, irq_enable_reg};
			default:             rdata_next = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			reg_rdata <= 32'h0;
		else if (reg_read)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 32'h0;
	end

	property p_start_follows_pulse;
		@(posedge clk_sys) disable iff (reset)
		first_pulse |=> cycle_start;
	endproperty
	a_start_follows_pulse: assert property (p_start_follows_pulse) else $error("cycle start missing"); // R03

	property p_no_spurious_start;
		@(posedge clk_sys) disable iff (reset)
		!first_pulse |=> !cycle_start;
	endproperty
	a_no_spurious_start: assert property (p_no_spurious_start) else $error("cycle start without pulse"); // R01

	property p_unshifted_output;
		@(posedge clk_sys) disable iff (reset)
		(second_pulse && !control_reg[CTL_OUT_SHIFT_EN] && u_out_shift.state_reg == SH_IDLE) |-> ##2 output_valid;
	endproperty
	a_unshifted_output: assert property (p_unshifted_output) else $error("output valid late"); // R04

	property p_unshifted_input;
		@(posedge clk_sys) disable iff (reset)
		(second_pulse && !control_reg[CTL_IN_SHIFT_EN] && u_in_shift.state_reg == SH_IDLE) |-> ##2 input_latch;
	endproperty
	a_unshifted_input: assert property (p_unshifted_input) else $error("input latch late"); // R04

	property p_sync_types;
		@(posedge clk_sys) disable iff (reset)
		reg_read && reg_addr == IDX_OUT_SYNC_TYPE |=> reg_rdata == 32'h3;
	endproperty
	a_sync_types: assert property (p_sync_types) else $error("output sync type wrong"); // R06

	property p_in_sync_type;
		@(posedge clk_sys) disable iff (reset)
		reg_read && reg_addr == IDX_IN_SYNC_TYPE |=> reg_rdata == 32'h1;
	endproperty
	a_in_sync_type: assert property (p_in_sync_type) else $error("input sync type wrong"); // R07

	property p_cycle_time_capture;
		@(posedge clk_sys) disable iff (reset)
		second_pulse |=> out_cycle_time_reg == $past(second_period);
	endproperty
	a_cycle_time_capture: assert property (p_cycle_time_capture) else $error("cycle time not captured"); // R08

	// Checked at the read port so a correct field cannot hide a broken read path
	property p_supported_dc;
		@(posedge clk_sys) disable iff (reset)
		reg_read && (reg_addr == IDX_OUT_SUPPORTED || reg_addr == IDX_IN_SUPPORTED) |=> reg_rdata[3:2] == 2'h2;
	endproperty
	a_supported_dc: assert property (p_supported_dc) else $error("supported bits wrong"); // R10

	property p_overrun_counts;
		@(posedge clk_sys) disable iff (reset || control_reg[CTL_COUNT_CLR])
		(overrun && too_small_reg != 16'hffff) |=> too_small_reg == $past(too_small_reg) + 16'h1 && sync_error_reg;
	endproperty
	a_overrun_counts: assert property (p_overrun_counts) else $error("overrun not counted"); // R17
endmodule : sync_cycle_core
`default_nettype wire

/* sync_cycle_pkg.sv */
// Constants for the subordinate-cycle synchronisation block
package sync_cycle_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_OUT_SYNC_TYPE   = 8'h00;
	localparam logic [7:0] IDX_OUT_CYCLE_TIME  = 8'h01;
	localparam logic [7:0] IDX_OUT_SHIFT_TIME  = 8'h02;
	localparam logic [7:0] IDX_OUT_SUPPORTED   = 8'h03;
	localparam logic [7:0] IDX_OUT_MIN_CYCLE   = 8'h04;
	localparam logic [7:0] IDX_OUT_CALC_COPY   = 8'h05;
	localparam logic [7:0] IDX_OUT_GET_CYCLE   = 8'h06;
	localparam logic [7:0] IDX_OUT_DELAY       = 8'h07;
	localparam logic [7:0] IDX_OUT_FIRST_PER   = 8'h08;
	localparam logic [7:0] IDX_OUT_TOO_SMALL   = 8'h09;
	localparam logic [7:0] IDX_OUT_MISSED      = 8'h0a;
	localparam logic [7:0] IDX_OUT_SHIFT_SHORT = 8'h0b;
	localparam logic [7:0] IDX_OUT_TOGGLE_FAIL = 8'h0c;
	localparam logic [7:0] IDX_OUT_SYNC_ERROR  = 8'h0d;
	localparam logic [7:0] IDX_IN_SYNC_TYPE    = 8'h10;
	localparam logic [7:0] IDX_IN_CYCLE_TIME   = 8'h11;
	localparam logic [7:0] IDX_IN_SHIFT_TIME   = 8'h12;
	localparam logic [7:0] IDX_IN_SUPPORTED    = 8'h13;
	localparam logic [7:0] IDX_IN_FIRST_PER    = 8'h18;
	localparam logic [7:0] IDX_IN_TOO_SMALL    = 8'h19;
	localparam logic [7:0] IDX_IN_MISSED       = 8'h1a;
	localparam logic [7:0] IDX_IN_SHIFT_SHORT  = 8'h1b;
	localparam logic [7:0] IDX_IN_TOGGLE_FAIL  = 8'h1c;
	localparam logic [7:0] IDX_IN_SYNC_ERROR   = 8'h1d;
	localparam logic [7:0] IDX_CONTROL         = 8'h20;
	localparam logic [7:0] IDX_IRQ_STATUS      = 8'h21;
	localparam logic [7:0] IDX_IRQ_ENABLE      = 8'h22;
	localparam logic [7:0] IDX_IRQ_CLEAR       = 8'h23;
	// Fixed values
	localparam logic [15:0] OUT_SYNC_TYPE_RST  = 16'h0003;
	localparam logic [15:0] IN_SYNC_TYPE_RST   = 16'h0001;
	localparam logic [1:0]  SUPP_SUBORDINATE   = 2'h2;
	localparam logic [1:0]  SHIFT_NONE         = 2'h0;
	localparam logic [1:0]  SHIFT_LOCAL_TIMER  = 2'h1;
	localparam int          SUPP_DC_LSB        = 2;
	localparam int          SUPP_SHIFT_LSB     = 4;
	// Control register fields, then fixed read values of the min cycle, calc copy and delay entries
	localparam int          CTL_OUT_SHIFT_EN   = 0;
	localparam int          CTL_IN_SHIFT_EN    = 1;
	localparam int          CTL_VAR_CYCLE      = 2;
	localparam int          CTL_COUNT_CLR      = 3;
	localparam logic [31:0] MIN_CYCLE_RST      = 32'h00000000;
	localparam logic [31:0] CALC_COPY_RST      = 32'h00000000;
	localparam logic [31:0] DELAY_RST          = 32'h00000000;
	// Interrupt status bits
	localparam int          IRQ_TOO_SMALL      = 0;
	localparam int          IRQ_MISSED         = 1;
	localparam int          IRQ_SHIFT_SHORT    = 2;
	localparam int          IRQ_TOGGLE_FAIL    = 3;
	localparam int          IRQ_WIDTH          = 4;
	// Shift times are counted in ns; one tick is one 40 ns clock
	localparam int          CLK_PERIOD_NS      = 40;
	// Least time a local cycle needs between start and done
	localparam int          MIN_SHIFT_NS       = 40;
	localparam int          MIN_SHIFT_CYC      = (MIN_SHIFT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {SH_IDLE, SH_WAIT, SH_FIRE} shift_state_t;
endpackage : sync_cycle_pkg

/* shift_timer.sv */
// Delays one trigger pulse by a programmable time
`timescale 1ns/1ps
`default_nettype none
module shift_timer
	import sync_cycle_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Control
	input  wire logic        enable,
	input  wire logic [31:0] shift_ns,
	input  wire logic        trigger,
	// Result
	output logic             fire,
	output logic             too_short
);
	shift_state_t state_reg;
	logic [31:0]  count_reg;
	logic [31:0]  ticks;

	assign ticks = shift_ns / CLK_PERIOD_NS;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_reg <= SH_IDLE;
			count_reg <= 32'h0;
			fire      <= 1'b0;
			too_short <= 1'b0;
		end
		else
		begin
			fire      <= 1'b0;
			too_short <= 1'b0;
			case (state_reg)
				SH_IDLE:
				begin
					if (trigger && (!enable || ticks == 32'h0))
						fire <= 1'b1;
					else if (trigger)
					begin
						count_reg <= ticks - 32'h1;
						state_reg <= SH_WAIT;
					end
				end
				SH_WAIT:
				begin
					// A new trigger before expiry means the shift outlasts the period
					if (trigger)
					begin
						too_short <= 1'b1;
						count_reg <= ticks - 32'h1;
					end
					else if (count_reg == 32'h0)
					begin
						fire      <= 1'b1;
						state_reg <= SH_IDLE;
					end
					else
						count_reg <= count_reg - 32'h1;
				end
				default:
					state_reg <= SH_IDLE;
			endcase
		end
	end
endmodule : shift_timer
`default_nettype wire

/* sync_master_model.sv */
// Model of the network master that issues the sync pulses and their periods
`timescale 1ns/1ps
`default_nettype none
module sync_master_model
(
	// Clock
	input  wire logic        clk_sys,
	// Sync pulses and periods
	output logic             first_pulse,
	output logic             second_pulse,
	output logic [31:0]      first_period,
	output logic [31:0]      second_period
);
	initial
	begin
		first_pulse   = 1'b0;
		second_pulse  = 1'b0;
		first_period  = 32'h0;
		second_period = 32'h0;
	end

	// Periods are only valid with their pulse; junk afterwards exposes a late sample
	task automatic send_first(input logic [31:0] per);
		@(posedge clk_sys);
		first_pulse  <= 1'b1;
		first_period <= per;
		@(posedge clk_sys);
		first_pulse  <= 1'b0;
		first_period <= ~per;
	endtask : send_first

	task automatic send_second(input logic [31:0] per);
		@(posedge clk_sys);
		second_pulse  <= 1'b1;
		second_period <= per;
		@(posedge clk_sys);
		second_pulse  <= 1'b0;
		second_period <= ~per;
	endtask : send_second
endmodule : sync_master_model
`default_nettype wire

/* dc_subordinate_cycle_sync_test.sv */
// Self-checking testbench for the subordinate-cycle synchronisation block
`timescale 1ns/1ps
`default_nettype none
module dc_subordinate_cycle_sync_test;
	import sync_cycle_pkg::*;
	logic        clk_sys;
	logic        reset;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [31:0] reg_rdata;
	logic        first_pulse;
	logic        second_pulse;
	logic [31:0] second_period;
	logic [31:0] first_period;
	logic        cycle_done;
	logic        missed_event;
	logic        toggle_failed;
	logic        cycle_start;
	logic        output_valid;
	logic        input_latch;
	logic        irq;
	int          n_mismatch;
	int          checked;
	int          kc;
	int          ko;
	int          ki;
	int          ko0;

	sync_cycle_core sync_cycle_core_inst (
		.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.first_pulse(first_pulse), .second_pulse(second_pulse), .second_period(second_period),
		.first_period(first_period), .cycle_done(cycle_done), .missed_event(missed_event),
		.toggle_failed(toggle_failed), .cycle_start(cycle_start), .output_valid(output_valid),
		.input_latch(input_latch), .irq(irq));

	sync_master_model sync_master_model_inst (
		.clk_sys(clk_sys), .first_pulse(first_pulse), .second_pulse(second_pulse),
		.first_period(first_period), .second_period(second_period));

	initial
	begin
		clk_sys = 1'b0;
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		cycle_done = 1'b0;
		missed_event = 1'b0;
		toggle_failed = 1'b0;
		n_mismatch = 0;
		checked = 0;
	end

	always #20 clk_sys = ~clk_sys;

	task automatic results();
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_n(input int got, input int exp);
		chk(32'(got), 32'(exp));
	endtask : chk_n

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd

	// Pulses are one cycle; the strobe drops at the next edge
	task automatic pulse(input int which);
		@(posedge clk_sys);
		cycle_done <= (which == 0);
		missed_event <= (which == 1);
		toggle_failed <= (which == 2);
		@(posedge clk_sys);
		cycle_done <= 1'b0;
		missed_event <= 1'b0;
		toggle_failed <= 1'b0;
	endtask : pulse

	// Edge index at which each timing output first shows high; -1 if never
	task automatic measure(output int c, output int o, output int i);
		c = -1;
		o = -1;
		i = -1;
		for (int k = 0; k < 24; k++)
		begin
			#1;
			if (cycle_start === 1'b1 && c < 0) c = k;
			if (output_valid === 1'b1 && o < 0) o = k;
			if (input_latch === 1'b1 && i < 0) i = k;
			@(posedge clk_sys);
		end
	endtask : measure

	initial
	begin
		#(40 * 3000);
		n_mismatch++;
		results();
	end

	initial
	begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		rd(8'h00, 32'h3);
		rd(8'h10, 32'h1);
		rd(8'h03, 32'h8);
		rd(8'h13, 32'h8);
		rd(8'h30, 32'h0);
		wr(8'h04, 32'h55);
		rd(8'h04, 32'h0);
		wr(8'h06, 32'h1234);
		rd(8'h06, 32'h1234);
		wr(8'h01, 32'habcd);
		rd(8'h01, 32'habcd);
		sync_master_model_inst.send_second(32'h30d40);
		measure(kc, ko0, ki);
		chk_n(ko0, 1);
		chk_n(ki, 1);
		rd(8'h01, 32'h30d40);
		rd(8'h11, 32'h30d40);
		sync_master_model_inst.send_first(32'h4e20);
		measure(kc, ko, ki);
		chk_n(kc, 0);
		chk_n(ko, -1);
		pulse(0);
		rd(8'h08, 32'h4e20);
		rd(8'h18, 32'h4e20);
		// Output shifted by 200 ns, five clocks; input left unshifted
		wr(8'h20, 32'h1);
		wr(8'h02, 32'hc8);
		rd(8'h02, 32'hc8);
		rd(8'h03, 32'h18);
		rd(8'h13, 32'h8);
		sync_master_model_inst.send_second(32'h30d40);
		measure(kc, ko, ki);
		chk_n(ko, ko0 + 5);
		chk_n(ki, ko0);
		sync_master_model_inst.send_second(32'h30d40);
		sync_master_model_inst.send_second(32'h30d40);
		repeat (12) @(posedge clk_sys);
		rd(8'h0b, 32'h1);
		rd(8'h1b, 32'h1);
		wr(8'h20, 32'h3);
		rd(8'h13, 32'h18);
		// Two first pulses with no done in between overrun the local cycle
		sync_master_model_inst.send_first(32'h4e20);
		sync_master_model_inst.send_first(32'h4e20);
		rd(8'h09, 32'h1);
		rd(8'h19, 32'h1);
		rd(8'h0d, 32'h1);
		rd(8'h1d, 32'h1);
		chk(32'(irq), 32'h0);
		wr(8'h22, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk(32'(irq), 32'h1);
		wr(8'h23, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk(32'(irq), 32'h0);
		pulse(1);
		pulse(2);
		rd(8'h0a, 32'h1);
		rd(8'h1a, 32'h1);
		rd(8'h0c, 32'h1);
		rd(8'h1c, 32'h1);
		// Counter clear and variable-cycle flag; status bits must survive the clear
		wr(8'h20, 32'hc);
		rd(8'h20, 32'hc);
		rd(8'h09, 32'h0);
		rd(8'h0b, 32'h0);
		rd(8'h1a, 32'h0);
		wr(8'h20, 32'h0);
		rd(8'h21, 32'he);
		results();
	end
endmodule : dc_subordinate_cycle_sync_test
`default_nettype wire
